// file: pwr_mode_regs.svh
/*
  Register offsets, field positions, reset values and timing counts
  for the power-mode and wake-up controller.
  Assumes a 200 MHz system clock and 8-bit byte addresses on a 32-bit data bus.
*/
`ifndef PWR_MODE_REGS_SVH
`define PWR_MODE_REGS_SVH

////////////////////////////////////////////////////////////////////////
// Register offsets
`define OFF_CTRL       8'h00
`define OFF_COD_EN     8'h04
`define OFF_RADIO      8'h08
`define OFF_THRESH     8'h0C
`define OFF_WAKE_CNT   8'h10
`define OFF_STATUS     8'h14
`define OFF_EVENT      8'h18

////////////////////////////////////////////////////////////////////////
// Field positions
`define CTRL_MON_SRC   0
`define CTRL_SLEEP     1
`define CTRL_HALT      2
`define EV_BATT        0
`define EV_RTC         1

////////////////////////////////////////////////////////////////////////
// Reset values
`define RST_COD_EN     4'h0
`define RST_RADIO      2'h0
`define RST_THRESH     8'h80
`define RST_WAKE_CNT   16'h0000

////////////////////////////////////////////////////////////////////////
// Timing
`define CLK_MHZ        200
`define PWRUP_TIME_NS  10000
`define PWRUP_CYC      ((`PWRUP_TIME_NS * `CLK_MHZ + 999) / 1000)

`endif

// file: pwr_mode_pkg.sv
/*
  Types shared by the power-mode controller and its clock gate.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pwr_mode_pkg;

  typedef logic [3:0]  dom_t;
  typedef logic [3:0]  per_t;
  typedef logic [7:0]  irq_t;
  typedef logic [7:0]  level_t;
  typedef logic [7:0]  addr_t;
  typedef logic [31:0] word_t;

  typedef enum logic [1:0] {
    ST_ACTIVE   = 2'b00,
    ST_SLEEP    = 2'b01,
    ST_POWER_UP = 2'b10
  } pwr_state_e;

  typedef enum logic [1:0] {
    WK_NONE  = 2'b00,
    WK_RTC   = 2'b01,
    WK_EXT   = 2'b10,
    WK_RESET = 2'b11
  } wake_cause_e;

  typedef struct packed {
    dom_t dom_en;
    per_t per_en;
  } clkg_s;

  typedef struct packed {
    pwr_state_e  st;
    logic        core_on;
    logic        mon_src;
    logic        sleep_req;
    logic        cpu_halt;
    dom_t        cod_en;
    logic [1:0]  radio;
    level_t      thresh;
    logic [15:0] wake_cnt;
    wake_cause_e cause;
    logic        on_batt;
    logic        ev_batt;
    logic        ev_rtc;
    logic        strap_ok;
    logic        strap_reg;
    logic        strap_clk;
    logic [11:0] pwr_cnt;
    word_t       rdata;
    logic        ext_en;
    logic        reg_en;
    logic        ext_sup_en;
    logic [4:0]  bank_n;
    logic        rd_n;
    logic        io_wr_n;
    logic        io_sel_n;
    logic [3:0]  ben_n;
    logic        dir;
    logic [1:0]  radio_o;
  } pwr_s;

endpackage

// file: clk_gate_if.sv
/*
  Signals between the power-mode controller and its clock gate.
  Assumes both ends share the system clock.
*/
interface clk_gate_if;
  import pwr_mode_pkg::*;

  dom_t cod_en;
  dom_t dom_busy;
  logic cpu_halt;
  logic core_on;
  per_t per_busy;
  dom_t dom_clk_en;
  per_t per_clk_en;

  modport ctrl (output cod_en, dom_busy, cpu_halt, core_on, per_busy,
                input  dom_clk_en, per_clk_en);
  modport gate (input  cod_en, dom_busy, cpu_halt, core_on, per_busy,
                output dom_clk_en, per_clk_en);
endinterface

// file: clk_demand_gate.sv
/*
  Per-domain and per-peripheral clock enables.
  Assumes domain 0 is the processor and enables feed glitch-free gates.
*/
module clk_demand_gate
  import pwr_mode_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  input  wire logic i_pin_reset_low,
  clk_gate_if.gate  gif
);

  clkg_s q;
  clkg_s d;
  dom_t  dom_want;
  per_t  per_want;

  ////////////////////////////////////////////////////////////////////
  // Enable decisions
  assign dom_want[0] = gif.core_on & (~gif.cod_en[0] | ~gif.cpu_halt);

  for (genvar g = 1; g < 4; g++) begin : g_dom
    // Domain owns its gating only while its option is on
    assign dom_want[g] = gif.core_on & (~gif.cod_en[g] | gif.dom_busy[g]);
  end

  for (genvar p = 0; p < 4; p++) begin : g_per
    assign per_want[p] = gif.core_on & gif.per_busy[p];
  end

  always_comb begin
    d        = q;
    d.dom_en = dom_want;
    d.per_en = per_want;
  end

  always_ff @(posedge i_sys_clk or negedge i_pin_reset_low) begin
    if (!i_pin_reset_low) begin
      q <= '0;
    end else if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign gif.dom_clk_en = q.dom_en;
  assign gif.per_clk_en = q.per_en;

endmodule // clk_demand_gate

// file: power_mode_wake_control.sv
/*
  Power-mode and wake-up controller: sleep entry, always-on wake logic,
  clock-on-demand enables, supply supervisor switchover and pin safe states.
  Assumes all inputs synchronous to i_sys_clk except the low-active pin reset.
*/
`include "pwr_mode_regs.svh"

// Contract
// - In active operation each peripheral clock runs only while it is busy.
// - Sleep is entered only when idle; core supply and external parts go off.
// - In sleep, RTC wake, external wake or reset restart the system.
// - Each clock sub-domain has its own clock-on-demand enable bit.
// - With clock-on-demand on, a domain's own activity gates its clock.
// - Processor may halt its clock; a peripheral interrupt restarts it.
// - Supervisor watches core or pad-ring supply, chosen by software.
// - Monitored supply below threshold moves RTC and backup memory to battery.
// - Pin reset is active low and asynchronous.
// - External-component enable output stays valid with core supply off.
// - Core off: bank selects, strobes, byte enables high; direction low.
// - Two outputs set the radio front end power mode.
// - The RTC can raise a wake request out of power-down.
module power_mode_wake_control
  import pwr_mode_pkg::*;
(
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_pin_reset_low,
  input  wire logic                 i_pin_wake_request,
  input  wire logic                 i_regulator_source_strap,
  input  wire logic                 i_clock_source_strap,
  input  wire logic                 i_rtc_tick,
  input  wire logic                 i_core_supply_good,
  input  wire pwr_mode_pkg::level_t i_core_level,
  input  wire pwr_mode_pkg::level_t i_pad_level,
  input  wire pwr_mode_pkg::irq_t   i_periph_irq,
  input  wire pwr_mode_pkg::dom_t   i_dom_busy,
  input  wire pwr_mode_pkg::per_t   i_per_busy,
  input  wire pwr_mode_pkg::addr_t  i_addr,
  input  wire pwr_mode_pkg::word_t  i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  input  wire logic [4:0]           i_mem_bank_n,
  input  wire logic                 i_mem_read_n,
  input  wire logic                 i_mem_io_wr_n,
  input  wire logic                 i_mem_io_sel_n,
  input  wire logic [3:0]           i_mem_ben_n,
  input  wire logic                 i_mem_dir,
  output      pwr_mode_pkg::word_t  o_rdata,
  output      logic                 o_ext_en,
  output      logic                 o_core_reg_en,
  output      logic                 o_core_ext_supply_en,
  output      logic                 o_osc_select,
  output      logic                 o_core_on,
  output      logic [1:0]           o_radio_mode,
  output      logic                 o_backup_on_battery,
  output      pwr_mode_pkg::dom_t   o_dom_clk_en,
  output      pwr_mode_pkg::per_t   o_per_clk_en,
  output      logic                 o_boot_bank_select_n,
  output      logic [2:0]           o_bank_select_n,
  output      logic                 o_fifth_bank_select_n,
  output      logic                 o_mem_read_strobe_n,
  output      logic                 o_io_write_strobe_n,
  output      logic                 o_io_space_select_n,
  output      logic [3:0]           o_byte_write_strobe_n,
  output      logic                 o_data_dir
);
  import pwr_mode_pkg::*;

  // Last count of the power-up wait
  localparam logic [11:0] PWRUP_LAST = 12'(`PWRUP_CYC - 1);

  // Reset image of all state
  localparam pwr_s RST_VAL = '{
    st:         ST_POWER_UP,
    core_on:    1'b0,
    mon_src:    1'b0,
    sleep_req:  1'b0,
    cpu_halt:   1'b0,
    cod_en:     `RST_COD_EN,
    radio:      `RST_RADIO,
    thresh:     `RST_THRESH,
    wake_cnt:   `RST_WAKE_CNT,
    cause:      WK_RESET,
    on_batt:    1'b0,
    ev_batt:    1'b0,
    ev_rtc:     1'b0,
    strap_ok:   1'b0,
    strap_reg:  1'b0,
    strap_clk:  1'b0,
    pwr_cnt:    12'h000,
    rdata:      32'h0000_0000,
    ext_en:     1'b1,
    reg_en:     1'b0,
    ext_sup_en: 1'b0,
    bank_n:     5'h1F,
    rd_n:       1'b1,
    io_wr_n:    1'b1,
    io_sel_n:   1'b1,
    ben_n:      4'hF,
    dir:        1'b0,
    radio_o:    2'h0
  };

  pwr_s   q;
  pwr_s   d;
  level_t mon_level;
  logic   rtc_fire;
  logic   quiet;
  logic   core_on_d;

  clk_gate_if gif ();

  ////////////////////////////////////////////////////////////////////
  // Address decode
  function automatic logic hit(input addr_t a, input addr_t off);
    return a == off;
  endfunction

  function automatic logic is_awake(input pwr_state_e s);
    return s != ST_SLEEP;
  endfunction

  function automatic logic is_active(input pwr_state_e s);
    return s == ST_ACTIVE;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d         = q;
    rtc_fire  = 1'b0;
    quiet     = ~|i_dom_busy & ~|i_per_busy & ~|i_periph_irq;
    mon_level = q.mon_src ? i_pad_level : i_core_level;

    ////////////////////////////////////////////////////////////////////
    // Straps caught once after reset release
    if (!q.strap_ok) begin
      d.strap_ok  = 1'b1;
      d.strap_reg = i_regulator_source_strap;
      d.strap_clk = i_clock_source_strap;
    end

    ////////////////////////////////////////////////////////////////////
    // Register writes
    if (i_wr) begin
      if (hit(i_addr, `OFF_CTRL)) begin
        d.mon_src = i_wdata[`CTRL_MON_SRC];
        if (i_wdata[`CTRL_SLEEP]) begin
          d.sleep_req = 1'b1;
        end
        if (i_wdata[`CTRL_HALT]) begin
          d.cpu_halt = 1'b1;
        end
      end
      if (hit(i_addr, `OFF_COD_EN)) begin
        d.cod_en = i_wdata[3:0];
      end
      if (hit(i_addr, `OFF_RADIO)) begin
        d.radio = i_wdata[1:0];
      end
      if (hit(i_addr, `OFF_THRESH)) begin
        d.thresh = i_wdata[7:0];
      end
      if (hit(i_addr, `OFF_WAKE_CNT)) begin
        d.wake_cnt = i_wdata[15:0];
      end
      if (hit(i_addr, `OFF_EVENT)) begin
        d.ev_batt = q.ev_batt & ~i_wdata[`EV_BATT];
        d.ev_rtc  = q.ev_rtc & ~i_wdata[`EV_RTC];
      end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt wins over a halt written in the same cycle
    if (|i_periph_irq) begin
      d.cpu_halt = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Supervisor switchover
    d.on_batt = mon_level < q.thresh;
    if (d.on_batt && !q.on_batt) begin
      d.ev_batt = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // Power sequencing
    unique case (q.st)
      ST_ACTIVE: begin
        d.pwr_cnt = 12'h000;
        if (q.sleep_req && quiet) begin
          d.st        = ST_SLEEP;
          d.sleep_req = 1'b0;
          d.cause     = WK_NONE;
        end
      end
      ST_SLEEP: begin
        d.sleep_req = 1'b0;
        if (i_rtc_tick && q.wake_cnt != 16'h0000) begin
          d.wake_cnt = q.wake_cnt - 16'h0001;
          rtc_fire   = q.wake_cnt == 16'h0001;
        end
        if (i_pin_wake_request) begin
          d.st    = ST_POWER_UP;
          d.cause = WK_EXT;
        end else if (rtc_fire) begin
          d.st    = ST_POWER_UP;
          d.cause = WK_RTC;
        end
        if (rtc_fire) begin
          d.ev_rtc = 1'b1;
        end
      end
      ST_POWER_UP: begin
        d.sleep_req = 1'b0;
        if (q.pwr_cnt < PWRUP_LAST) begin
          d.pwr_cnt = q.pwr_cnt + 12'h001;
        end else if (i_core_supply_good) begin
          d.st      = ST_ACTIVE;
          d.pwr_cnt = 12'h000;
        end
      end
      default: begin
        d.st = ST_POWER_UP;
      end
    endcase

    ////////////////////////////////////////////////////////////////////
    // Supply and external enables
    core_on_d    = is_active(d.st);
    d.core_on    = core_on_d;
    d.ext_en     = is_awake(d.st);
    d.reg_en     = is_awake(d.st) & d.strap_reg & d.strap_ok;
    d.ext_sup_en = is_awake(d.st) & ~d.strap_reg & d.strap_ok;

    ////////////////////////////////////////////////////////////////////
    // Memory pins rest in their safe levels without core power
    if (core_on_d) begin
      d.bank_n   = i_mem_bank_n;
      d.rd_n     = i_mem_read_n;
      d.io_wr_n  = i_mem_io_wr_n;
      d.io_sel_n = i_mem_io_sel_n;
      d.ben_n    = i_mem_ben_n;
      d.dir      = i_mem_dir;
      d.radio_o  = d.radio;
    end else begin
      d.bank_n   = 5'h1F;
      d.rd_n     = 1'b1;
      d.io_wr_n  = 1'b1;
      d.io_sel_n = 1'b1;
      d.ben_n    = 4'hF;
      d.dir      = 1'b0;
      d.radio_o  = 2'h0;
    end

    ////////////////////////////////////////////////////////////////////
    // Register reads, answered the next cycle
    d.rdata = 32'h0000_0000;
    if (i_rd) begin
      if (hit(i_addr, `OFF_CTRL)) begin
        d.rdata[`CTRL_MON_SRC] = q.mon_src;
        d.rdata[`CTRL_SLEEP]   = q.sleep_req;
        d.rdata[`CTRL_HALT]    = q.cpu_halt;
      end
      if (hit(i_addr, `OFF_COD_EN)) begin
        d.rdata[3:0] = q.cod_en;
      end
      if (hit(i_addr, `OFF_RADIO)) begin
        d.rdata[1:0] = q.radio;
      end
      if (hit(i_addr, `OFF_THRESH)) begin
        d.rdata[7:0] = q.thresh;
      end
      if (hit(i_addr, `OFF_WAKE_CNT)) begin
        d.rdata[15:0] = q.wake_cnt;
      end
      if (hit(i_addr, `OFF_STATUS)) begin
        d.rdata[1:0]  = q.st;
        d.rdata[3:2]  = q.cause;
        d.rdata[4]    = q.on_batt;
        d.rdata[5]    = q.strap_reg;
        d.rdata[6]    = q.strap_clk;
        d.rdata[7]    = q.cpu_halt;
        d.rdata[11:8] = gif.dom_clk_en;
        d.rdata[15:12] = gif.per_clk_en;
      end
      if (hit(i_addr, `OFF_EVENT)) begin
        d.rdata[`EV_BATT] = q.ev_batt;
        d.rdata[`EV_RTC]  = q.ev_rtc;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_sys_clk or negedge i_pin_reset_low) begin
    if (!i_pin_reset_low) begin
      q <= RST_VAL;
    end else if (i_rst) begin
      q <= RST_VAL;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Clock gating
  assign gif.cod_en   = q.cod_en;
  assign gif.dom_busy = i_dom_busy;
  assign gif.cpu_halt = q.cpu_halt;
  assign gif.core_on  = q.core_on;
  assign gif.per_busy = i_per_busy;

  clk_demand_gate u_gate (
    .i_sys_clk       (i_sys_clk),
    .i_rst           (i_rst),
    .i_pin_reset_low (i_pin_reset_low),
    .gif             (gif.gate)
  );

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_rdata               = q.rdata;
  assign o_ext_en              = q.ext_en;
  assign o_core_reg_en         = q.reg_en;
  assign o_core_ext_supply_en  = q.ext_sup_en;
  assign o_osc_select          = q.strap_clk;
  assign o_core_on             = q.core_on;
  assign o_radio_mode          = q.radio_o;
  assign o_backup_on_battery   = q.on_batt;
  assign o_dom_clk_en          = gif.dom_clk_en;
  assign o_per_clk_en          = gif.per_clk_en;
  assign o_boot_bank_select_n  = q.bank_n[0];
  assign o_bank_select_n       = q.bank_n[3:1];
  assign o_fifth_bank_select_n = q.bank_n[4];
  assign o_mem_read_strobe_n   = q.rd_n;
  assign o_io_write_strobe_n   = q.io_wr_n;
  assign o_io_space_select_n   = q.io_sel_n;
  assign o_byte_write_strobe_n = q.ben_n;
  assign o_data_dir            = q.dir;

endmodule // power_mode_wake_control

// file: pwr_mode_asserts.sv
/*
  Port assertions for the power-mode and wake-up controller.
  Assumes the bind at the foot of this file and one system clock.
*/
module pwr_mode_asserts
  import pwr_mode_pkg::*;
(
  input wire logic                 i_sys_clk,
  input wire logic                 i_rst,
  input wire logic                 i_pin_reset_low,
  input wire logic                 i_pin_wake_request,
  input wire pwr_mode_pkg::level_t i_core_level,
  input wire pwr_mode_pkg::level_t i_pad_level,
  input wire pwr_mode_pkg::irq_t   i_periph_irq,
  input wire pwr_mode_pkg::per_t   i_per_busy,
  input wire logic                 o_ext_en,
  input wire logic                 o_core_reg_en,
  input wire logic                 o_core_ext_supply_en,
  input wire logic                 o_core_on,
  input wire logic [1:0]           o_radio_mode,
  input wire logic                 o_backup_on_battery,
  input wire pwr_mode_pkg::dom_t   o_dom_clk_en,
  input wire pwr_mode_pkg::per_t   o_per_clk_en,
  input wire logic                 o_boot_bank_select_n,
  input wire logic [2:0]           o_bank_select_n,
  input wire logic                 o_fifth_bank_select_n,
  input wire logic                 o_mem_read_strobe_n,
  input wire logic                 o_io_write_strobe_n,
  input wire logic                 o_io_space_select_n,
  input wire logic [3:0]           o_byte_write_strobe_n,
  input wire logic                 o_data_dir
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst || !i_pin_reset_low);

  ////////////////////////////////////////////////////////////////////////
  // Sequences
  sequence s_on3;
    o_core_on ##1 o_core_on ##1 o_core_on;
  endsequence
  sequence s_irq_on;
    (o_core_on && (i_periph_irq != 8'h00)) ##1 o_core_on ##1 o_core_on;
  endsequence

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  a_safe_pins_off: assert property (
    !o_core_on |-> ({o_fifth_bank_select_n, o_bank_select_n, o_boot_bank_select_n,
    o_mem_read_strobe_n, o_io_write_strobe_n, o_io_space_select_n,
    o_byte_write_strobe_n, o_data_dir} == 13'h1FFE))
    else $error("safe pin levels wrong while core off");
  a_pin_reset_async: assert property (
    disable iff (i_rst) !i_pin_reset_low |-> o_ext_en && !o_core_on && !o_data_dir)
    else $error("pin reset did not force reset levels");
  a_wake_ext_en: assert property (
    !o_ext_en && i_pin_wake_request |-> ##[1:2] o_ext_en)
    else $error("external wake did not restart");
  a_sleep_drops: assert property (
    $fell(o_core_on) |-> ##[0:1] !(o_ext_en || o_core_reg_en || o_core_ext_supply_en))
    else $error("sleep entry left supplies on");
  a_ext_en_core_on: assert property (
    o_core_on |-> o_ext_en)
    else $error("external enable low while core on");
  a_per_clk_busy: assert property (
    s_on3 |-> o_per_clk_en == $past(i_per_busy))
    else $error("peripheral clock not following activity");
  a_irq_restarts_cpu: assert property (
    s_irq_on |-> o_dom_clk_en[0])
    else $error("interrupt did not restart processor clock");
  a_batt_healthy: assert property (
    (i_core_level == 8'hFF) && (i_pad_level == 8'hFF) |=> !o_backup_on_battery)
    else $error("battery selected with healthy supplies");
  a_radio_off: assert property (
    !o_core_on ##1 !o_core_on |-> o_radio_mode == 2'h0)
    else $error("radio mode not off while core off");
endmodule // pwr_mode_asserts

bind power_mode_wake_control pwr_mode_asserts chk_u (
  .i_sys_clk, .i_rst, .i_pin_reset_low, .i_pin_wake_request, .i_core_level, .i_pad_level,
  .i_periph_irq, .i_per_busy, .o_ext_en, .o_core_reg_en, .o_core_ext_supply_en, .o_core_on,
  .o_radio_mode, .o_backup_on_battery, .o_dom_clk_en, .o_per_clk_en, .o_boot_bank_select_n,
  .o_bank_select_n, .o_fifth_bank_select_n, .o_mem_read_strobe_n, .o_io_write_strobe_n,
  .o_io_space_select_n, .o_byte_write_strobe_n, .o_data_dir);

// file: board_supply_model.sv
/*
  Board around the controller: core supply, supply levels and straps.
  Assumes the bench clock; SETTLE sets how slowly the supply comes good.
*/
module board_supply_model #(
  parameter int SETTLE = 8
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_supply_en,
  input  wire logic       i_brownout,
  output      logic       o_supply_good,
  output      logic [7:0] o_core_level,
  output      logic [7:0] o_pad_level,
  output      logic       o_regulator_source_strap,
  output      logic       o_clock_source_strap
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;

  ////////////////////////////////////////////////////////////////////////
  // Straps and supplies
  assign o_regulator_source_strap = 1'b1;
  assign o_clock_source_strap     = 1'b1;
  assign o_pad_level   = 8'hFF;
  assign o_supply_good = (cnt >= SETTLE);
  assign o_core_level  = (o_supply_good && !i_brownout) ? 8'hFF : 8'h10;

  always @(posedge i_sys_clk) begin
    if (!i_supply_en) begin
      cnt <= 0;
    end else if (cnt < SETTLE) begin
      cnt <= cnt + 1;
    end
  end
endmodule // board_supply_model

// file: tb_power_mode_wake_control.sv
/*
  Self-checking bench for the power-mode and wake-up controller.
  Assumes the board model beside it and the checker bound to the design.
*/
`include "pwr_mode_regs.svh"
module tb_power_mode_wake_control;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
  } row_s;
  logic        i_sys_clk, i_rst, i_pin_reset_low, i_pin_wake_request, i_rtc_tick;
  logic        i_wr, i_rd, i_mem_read_n, i_mem_io_wr_n, i_mem_io_sel_n, i_mem_dir, brownout;
  logic [7:0]  i_periph_irq, i_addr;
  logic [3:0]  i_dom_busy, i_per_busy, i_mem_ben_n;
  logic [4:0]  i_mem_bank_n;
  logic [31:0] i_wdata, rd_data;
  wire logic   i_regulator_source_strap, i_clock_source_strap, i_core_supply_good;
  wire logic [7:0]  i_core_level, i_pad_level;
  wire logic [31:0] o_rdata;
  wire logic   o_ext_en, o_core_reg_en, o_core_ext_supply_en, o_osc_select, o_core_on;
  wire logic   o_backup_on_battery, o_boot_bank_select_n, o_fifth_bank_select_n, o_data_dir;
  wire logic   o_mem_read_strobe_n, o_io_write_strobe_n, o_io_space_select_n;
  wire logic [1:0]  o_radio_mode;
  wire logic [2:0]  o_bank_select_n;
  wire logic [3:0]  o_dom_clk_en, o_per_clk_en, o_byte_write_strobe_n;
  wire logic [12:0] pins = {o_fifth_bank_select_n, o_bank_select_n, o_boot_bank_select_n,
    o_mem_read_strobe_n, o_io_write_strobe_n, o_io_space_select_n, o_byte_write_strobe_n,
    o_data_dir};
  int fail_count = 0;
  int n_checks = 0;
  row_s rows [5] = '{'{`OFF_COD_EN, 32'hFFFF_FFFF, 32'h0000_000F},
    '{`OFF_RADIO, 32'h0000_0007, 32'h0000_0003}, '{`OFF_THRESH, 32'h0000_0140, 32'h0000_0040},
    '{`OFF_WAKE_CNT, 32'h0001_2345, 32'h0000_2345}, '{8'h1C, 32'hFFFF_FFFF, 32'h0000_0000}};
  row_s rst_rows [4] = '{'{`OFF_COD_EN, 32'h0, 32'h0}, '{`OFF_RADIO, 32'h0, 32'h0},
    '{`OFF_THRESH, 32'h0, 32'h0000_0080}, '{`OFF_WAKE_CNT, 32'h0, 32'h0}};

  ////////////////////////////////////////////////////////////////////////
  // Design and board
  power_mode_wake_control dut_u (
    .i_sys_clk, .i_rst, .i_pin_reset_low, .i_pin_wake_request, .i_regulator_source_strap,
    .i_clock_source_strap, .i_rtc_tick, .i_core_supply_good, .i_core_level, .i_pad_level,
    .i_periph_irq, .i_dom_busy, .i_per_busy, .i_addr, .i_wdata, .i_wr, .i_rd, .i_mem_bank_n,
    .i_mem_read_n, .i_mem_io_wr_n, .i_mem_io_sel_n, .i_mem_ben_n, .i_mem_dir, .o_rdata,
    .o_ext_en, .o_core_reg_en, .o_core_ext_supply_en, .o_osc_select, .o_core_on,
    .o_radio_mode, .o_backup_on_battery, .o_dom_clk_en, .o_per_clk_en, .o_boot_bank_select_n,
    .o_bank_select_n, .o_fifth_bank_select_n, .o_mem_read_strobe_n, .o_io_write_strobe_n,
    .o_io_space_select_n, .o_byte_write_strobe_n, .o_data_dir);
  board_supply_model #(.SETTLE(8)) brd_u (
    .i_sys_clk, .i_supply_en(o_core_reg_en | o_core_ext_supply_en), .i_brownout(brownout),
    .o_supply_good(i_core_supply_good), .o_core_level(i_core_level),
    .o_pad_level(i_pad_level), .o_regulator_source_strap(i_regulator_source_strap),
    .o_clock_source_strap(i_clock_source_strap));

  ////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  task automatic wait_for(input logic ext, input logic v);
    for (int i = 0; i < 5000; i++) begin
      tick(1);
      if ((ext ? o_ext_en : o_core_on) === v) return;
    end
    fail_count++;
    print_verdict();
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Stimulus
  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  initial begin
    {i_rst, i_pin_reset_low, i_pin_wake_request, i_rtc_tick, i_wr, i_rd} = 6'h30;
    {brownout, i_periph_irq, i_addr, i_wdata} = '0;
    {i_dom_busy, i_per_busy} = 8'h4A;
    {i_mem_bank_n, i_mem_read_n, i_mem_io_wr_n, i_mem_io_sel_n, i_mem_ben_n, i_mem_dir} = 13'h154D;
    repeat (6) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    wait_for(1'b0, 1'b1);
    chk(32'({o_osc_select, o_core_reg_en, o_core_ext_supply_en}), 32'h6);
    foreach (rows[k]) begin
      wr(rows[k].addr, rows[k].wdata);
      rd(rows[k].addr, rd_data);
      chk(rd_data, rows[k].rdata);
    end
    tick(2);
    chk(32'(o_radio_mode), 32'h3);
    chk(32'({o_dom_clk_en, o_per_clk_en}), 32'h5A);
    chk(32'(pins), 32'h154D);
    wr(`OFF_CTRL, 32'h4);
    tick(3);
    chk(32'(o_dom_clk_en), 32'h4);
    @(posedge i_sys_clk);
    i_periph_irq <= 8'h80;
    @(posedge i_sys_clk);
    i_periph_irq <= 8'h00;
    tick(3);
    chk(32'(o_dom_clk_en), 32'h5);
    wr(`OFF_COD_EN, 32'h0);
    tick(3);
    chk(32'(o_dom_clk_en), 32'hF);
    @(posedge i_sys_clk);
    brownout <= 1'b1;
    tick(4);
    chk(32'(o_backup_on_battery), 32'h1);
    wr(`OFF_CTRL, 32'h1);
    tick(3);
    chk(32'(o_backup_on_battery), 32'h0);
    @(posedge i_sys_clk);
    brownout <= 1'b0;
    {i_dom_busy, i_per_busy} <= 8'h00;
    wr(`OFF_WAKE_CNT, 32'h2);
    wr(`OFF_CTRL, 32'h2);
    wait_for(1'b0, 1'b0);
    tick(2);
    chk(32'({pins, o_ext_en, o_radio_mode}), 32'hFFF0);
    repeat (2) begin
      @(posedge i_sys_clk);
      i_rtc_tick <= 1'b1;
      @(posedge i_sys_clk);
      i_rtc_tick <= 1'b0;
    end
    wait_for(1'b1, 1'b1);
    wait_for(1'b0, 1'b1);
    rd(`OFF_EVENT, rd_data);
    chk(rd_data & 32'h2, 32'h2);
    wr(`OFF_WAKE_CNT, 32'h0);
    @(posedge i_sys_clk);
    i_periph_irq <= 8'h01;
    wr(`OFF_CTRL, 32'h2);
    tick(10);
    chk(32'(o_core_on), 32'h1);
    @(posedge i_sys_clk);
    i_periph_irq <= 8'h00;
    wait_for(1'b0, 1'b0);
    @(posedge i_sys_clk);
    i_pin_wake_request <= 1'b1;
    wait_for(1'b1, 1'b1);
    @(posedge i_sys_clk);
    i_pin_wake_request <= 1'b0;
    wait_for(1'b0, 1'b1);
    rd(`OFF_STATUS, rd_data);
    chk(rd_data & 32'hC, 32'h8);
    @(posedge i_sys_clk);
    i_pin_reset_low <= 1'b0;
    #1;
    chk(32'({o_core_on, o_ext_en, o_data_dir}), 32'h2);
    @(posedge i_sys_clk);
    i_pin_reset_low <= 1'b1;
    foreach (rst_rows[k]) begin
      rd(rst_rows[k].addr, rd_data);
      chk(rd_data, rst_rows[k].rdata);
    end
    wait_for(1'b0, 1'b1);
    rd(`OFF_STATUS, rd_data);
    chk(rd_data & 32'hC, 32'hC);
    print_verdict();
  end
endmodule // tb_power_mode_wake_control
